// ===== hw/aim_alarm_monitor.sv
// Notes on behaviour
// (R01) Each finished conversion on a monitored channel is compared using its new value.
// (R02) Value above high limit sets high alarm; below low limit sets low alarm.
// (R03) Two modes, momentary or latching, applied to both alarms of a channel.
// (R04) Latching alarm stays on after values return within limits.
// (R05) Host clear-alarm command turns off latched alarms of the addressed channel.
// (R06) Latching: setting one alarm clears the opposite latched alarm.
// (R07) Momentary: alarm on only while value lies outside its limit.
// (R08) Per-channel enable set by host; disabled channel is not evaluated.
// (R09) With alarms enabled, drive option mirrors alarms onto assigned output points.
// (R10) Host reads high and low alarm states anytime without disturbing them.
// (R11) Any output point of any slot can serve as high or low alarm output.
// (R12) Assignments and limits downloaded by host are stored in non-volatile memory.
// (R13) Reset clears alarms and restores settings from storage before first comparison.
`default_nettype none
module aim_alarm_monitor
  import aim_pkg::*;
(
  input wire logic i_core_clk,                   // System clock, 50 MHz
  input wire logic i_sys_rst,                    // Synchronous reset, active high
  input wire aim_req_t i_req,                    // Host register request
  output logic [DW-1:0] o_rd_data,               // Read data, cycle after read
  input wire aim_conv_t i_conv,                  // Finished conversion
  output logic [NVM_AW-1:0] o_nvm_addr,          // Storage word address
  output logic [DW-1:0] o_nvm_wdata,             // Storage write data
  output logic o_nvm_we,                         // Storage write pulse
  output logic o_nvm_re,                         // Storage read pulse
  input wire logic [DW-1:0] i_nvm_rdata,         // Storage data, cycle after read
  output logic o_busy,                           // Restore in progress
  output logic [NUM_CH-1:0] o_alarm_hi,          // High alarm states
  output logic [NUM_CH-1:0] o_alarm_lo,          // Low alarm states
  output logic [NUM_PT-1:0] o_do_level,          // Alarm-driven output levels
  output logic [NUM_PT-1:0] o_do_owned           // Points claimed by alarms
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Output point decode, shared by high and low assignments
  function automatic logic [NUM_PT-1:0] pt_onehot(input logic [PT_W-1:0] pt);
    logic [NUM_PT-1:0] v;
    v = '0;
    v[pt] = 1'b1;
    return v;
  endfunction : pt_onehot

  // Place one stored word into a channel's settings
  function automatic aim_cfg_t put_word(input aim_cfg_t c, input logic [1:0] sel,
                                        input logic [DW-1:0] d);
    aim_cfg_t r;
    r = c;
    unique case (sel)
      2'b00: begin
        r.enable = d[CTRL_EN_BIT];
        r.drive = d[CTRL_DRV_BIT];
        r.latch = d[CTRL_LATCH_BIT];
      end
      2'b01: r.hi_lim = d;
      2'b10: r.lo_lim = d;
      2'b11: begin
        r.hi_pt = d[ASG_HI_LSB +: PT_W];
        r.lo_pt = d[ASG_LO_LSB +: PT_W];
      end
    endcase
    return r;
  endfunction : put_word

  // Read one stored word back out of a channel's settings
  function automatic logic [DW-1:0] get_word(input aim_cfg_t c, input logic [1:0] sel);
    logic [DW-1:0] d;
    d = DATA_ZERO;
    unique case (sel)
      2'b00: begin
        d[CTRL_EN_BIT] = c.enable;
        d[CTRL_DRV_BIT] = c.drive;
        d[CTRL_LATCH_BIT] = c.latch;
      end
      2'b01: d = c.hi_lim;
      2'b10: d = c.lo_lim;
      2'b11: begin
        d[ASG_HI_LSB +: PT_W] = c.hi_pt;
        d[ASG_LO_LSB +: PT_W] = c.lo_pt;
      end
    endcase
    return d;
  endfunction : get_word

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  aim_state_t state;
  aim_cfg_t cfg [NUM_CH];
  logic [NVM_AW-1:0] ld_cnt;
  logic [NVM_AW-1:0] ld_addr_d;
  logic ld_valid_d;
  logic [NVM_AW-1:0] ld_addr_d2;
  logic ld_valid_d2;
  logic [NUM_CH-1:0] alarm_hi;
  logic [NUM_CH-1:0] alarm_lo;
  logic [NUM_CH-1:0] next_hi;
  logic [NUM_CH-1:0] next_lo;
  logic [NUM_PT-1:0] next_do_level;
  logic [NUM_PT-1:0] next_do_owned;

  logic [CH_W-1:0] req_ch;
  logic [SEL_W-1:0] req_sel;
  logic cfg_wr;
  logic clr_go;
  logic conv_go;
  logic cv_over;
  logic cv_under;
  logic cv_latch;

  assign req_ch = i_req.addr[ADDR_W-1 -: CH_W];
  assign req_sel = i_req.addr[SEL_W-1:0];
  // Settings writes are refused while the restore walk still owns them
  assign cfg_wr = i_req.wr && (state == AIM_ST_RUN) && !req_sel[2];
  assign clr_go = i_req.wr && (req_sel == SEL_STATUS);
  // No comparison before settings are back, nor on a disabled channel
  assign conv_go = i_conv.valid && (state == AIM_ST_RUN) && cfg[i_conv.ch].enable; // [R01] [R08] [R13]
  assign cv_over = i_conv.value > cfg[i_conv.ch].hi_lim;
  assign cv_under = i_conv.value < cfg[i_conv.ch].lo_lim;
  assign cv_latch = cfg[i_conv.ch].latch;

  // ----------------------------------------------------------------
  // Restore sequencer
  // ----------------------------------------------------------------
  // Walks every stored word once after reset; the registered strobe plus the
  // storage's own latency bring each word back two edges after its address
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= AIM_ST_LOAD;
      ld_cnt <= '0;
      ld_valid_d <= 1'b0;
      ld_addr_d <= '0;
      ld_valid_d2 <= 1'b0;
      ld_addr_d2 <= '0;
    end else begin
      ld_valid_d <= (state == AIM_ST_LOAD);
      ld_addr_d <= ld_cnt;
      ld_valid_d2 <= ld_valid_d;
      ld_addr_d2 <= ld_addr_d;
      unique case (state)
        AIM_ST_LOAD: begin
          ld_cnt <= ld_cnt + 1'b1;
          if (ld_cnt == NVM_LAST) begin
            state <= AIM_ST_DRAIN;
          end
        end
        AIM_ST_DRAIN: state <= ld_valid_d ? AIM_ST_DRAIN : AIM_ST_RUN; // [R13]
        AIM_ST_RUN: state <= AIM_ST_RUN;
        default: state <= AIM_ST_LOAD;
      endcase
    end
  end

  // Settings: loaded from storage, then written by the host
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg[i] <= CFG_RESET;
      end
    end else if (ld_valid_d2) begin
      cfg[ld_addr_d2[NVM_AW-1 -: CH_W]] <= put_word(cfg[ld_addr_d2[NVM_AW-1 -: CH_W]],
                                                    ld_addr_d2[1:0], i_nvm_rdata); // [R13]
    end else if (cfg_wr) begin
      cfg[req_ch] <= put_word(cfg[req_ch], req_sel[1:0], i_req.wdata); // [R03] [R08] [R11]
    end
  end

  // Storage port: restore reads, then write-through of every settings write
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_nvm_addr <= '0;
      o_nvm_wdata <= DATA_ZERO;
      o_nvm_we <= 1'b0;
      o_nvm_re <= 1'b0;
    end else begin
      o_nvm_re <= 1'b0;
      o_nvm_we <= 1'b0;
      if (state == AIM_ST_LOAD) begin
        o_nvm_re <= 1'b1;
        o_nvm_addr <= ld_cnt;
      end else if (cfg_wr) begin
        o_nvm_we <= 1'b1; // [R12]
        o_nvm_addr <= {req_ch, req_sel[1:0]};
        o_nvm_wdata <= i_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm evaluation
  // ----------------------------------------------------------------
  // Clear first, then the conversion, so an alarm set in the clear cycle survives
  always_comb begin
    next_hi = alarm_hi;
    next_lo = alarm_lo;
    if (clr_go) begin
      next_hi[req_ch] = alarm_hi[req_ch] & ~i_req.wdata[STAT_HI_BIT]; // [R05]
      next_lo[req_ch] = alarm_lo[req_ch] & ~i_req.wdata[STAT_LO_BIT]; // [R05]
    end
    if (conv_go) begin
      if (cv_latch) begin
        if (cv_over) begin
          next_hi[i_conv.ch] = 1'b1; // [R02]
          next_lo[i_conv.ch] = 1'b0; // [R06]
        end else if (cv_under) begin
          next_lo[i_conv.ch] = 1'b1; // [R02]
          next_hi[i_conv.ch] = 1'b0; // [R06]
        end
        // In range: latched states hold [R04]
      end else begin
        next_hi[i_conv.ch] = cv_over; // [R07]
        next_lo[i_conv.ch] = cv_under; // [R07]
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      alarm_hi <= '0; // [R13]
      alarm_lo <= '0;
    end else begin
      alarm_hi <= next_hi;
      alarm_lo <= next_lo;
    end
  end

  // ----------------------------------------------------------------
  // Output drive and host reads
  // ----------------------------------------------------------------
  // Points shared by two channels are ORed rather than arbitrated
  always_comb begin
    next_do_level = '0;
    next_do_owned = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cfg[i].enable && cfg[i].drive) begin
        next_do_owned = next_do_owned | pt_onehot(cfg[i].hi_pt) | pt_onehot(cfg[i].lo_pt); // [R11]
        if (alarm_hi[i]) begin
          next_do_level = next_do_level | pt_onehot(cfg[i].hi_pt); // [R09]
        end
        if (alarm_lo[i]) begin
          next_do_level = next_do_level | pt_onehot(cfg[i].lo_pt); // [R09]
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_do_level <= '0;
      o_do_owned <= '0;
      o_alarm_hi <= '0;
      o_alarm_lo <= '0;
      o_busy <= 1'b1;
    end else begin
      o_do_level <= next_do_level;
      o_do_owned <= next_do_owned;
      o_alarm_hi <= alarm_hi;
      o_alarm_lo <= alarm_lo;
      o_busy <= (state != AIM_ST_RUN);
    end
  end

  // Reads have no side effect on any state
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= DATA_ZERO;
    end else begin
      o_rd_data <= DATA_ZERO;
      if (i_req.rd) begin
        if (!req_sel[2]) begin
          o_rd_data <= get_word(cfg[req_ch], req_sel[1:0]);
        end else if (req_sel == SEL_STATUS) begin
          o_rd_data[STAT_HI_BIT] <= alarm_hi[req_ch]; // [R10]
          o_rd_data[STAT_LO_BIT] <= alarm_lo[req_ch]; // [R10]
        end else if (req_sel == SEL_SYS) begin
          o_rd_data[SYS_BUSY_BIT] <= (state != AIM_ST_RUN);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  logic no_clr_same;
  assign no_clr_same = !(clr_go && (req_ch == i_conv.ch));

  sequence seq_over;
    conv_go && cv_over;
  endsequence
  sequence seq_under;
    conv_go && cv_under;
  endsequence
  sequence seq_in_range;
    conv_go && !cv_over && !cv_under;
  endsequence

  chk_high_set: assert property (seq_over |=> alarm_hi[$past(i_conv.ch)]) // [R02]
    else $error("high alarm not set above limit");
  chk_low_set: assert property (seq_under |=> alarm_lo[$past(i_conv.ch)]) // [R02]
    else $error("low alarm not set below limit");
  chk_mom_release: assert property ((seq_in_range and !cv_latch) // [R07]
      |=> !alarm_hi[$past(i_conv.ch)] && !alarm_lo[$past(i_conv.ch)])
    else $error("momentary alarm stayed on in range");
  chk_latch_hold: assert property ((seq_in_range and cv_latch && no_clr_same) // [R04]
      |=> alarm_hi[$past(i_conv.ch)] == $past(alarm_hi[i_conv.ch]))
    else $error("latched alarm changed in range");
  chk_opposite_clear: assert property ((seq_under and cv_latch) // [R06]
      |=> !alarm_hi[$past(i_conv.ch)])
    else $error("latched high alarm kept after low crossing");
  chk_clear_cmd: assert property ((clr_go && i_req.wdata[STAT_HI_BIT] && !conv_go) // [R05]
      |=> !alarm_hi[$past(req_ch)])
    else $error("clear command ignored");
  chk_disabled_hold: assert property ((i_conv.valid && !conv_go && !clr_go) // [R08]
      |=> alarm_hi == $past(alarm_hi) && alarm_lo == $past(alarm_lo))
    else $error("alarm changed without evaluation");
  chk_reset_off: assert property ($past(i_sys_rst) |-> alarm_hi == '0 && alarm_lo == '0) // [R13]
    else $error("alarms not off after reset");
  chk_read_pure: assert property ((i_req.rd && !conv_go) // [R10]
      |=> alarm_hi == $past(alarm_hi) && alarm_lo == $past(alarm_lo))
    else $error("read disturbed alarm state");
  chk_nvm_write: assert property (cfg_wr |=> o_nvm_we && // [R12]
      o_nvm_addr == $past({req_ch, req_sel[1:0]}) && o_nvm_wdata == $past(i_req.wdata))
    else $error("settings write not stored");

endmodule : aim_alarm_monitor
`default_nettype wire

// ===== hw/aim_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants and types of the analog alarm monitor
// ----------------------------------------------------------------
package aim_pkg;
  localparam int unsigned DW = 16;          // Register and sample width
  localparam int unsigned CH_W = 3;         // Channel index width
  localparam int unsigned NUM_CH = 8;       // Monitored analog channels
  localparam int unsigned PT_W = 7;         // Output point index {slot[2:0], point[3:0]}
  localparam int unsigned NUM_PT = 128;     // Eight slots of sixteen points
  localparam int unsigned SEL_W = 3;        // Register selector width
  localparam int unsigned ADDR_W = 6;       // {channel, selector}
  localparam int unsigned NVM_AW = 5;       // {channel, word}
  // Register selectors inside a channel block
  localparam logic [SEL_W-1:0] SEL_CTRL = 3'h0;
  localparam logic [SEL_W-1:0] SEL_HI_LIM = 3'h1;
  localparam logic [SEL_W-1:0] SEL_LO_LIM = 3'h2;
  localparam logic [SEL_W-1:0] SEL_ASSIGN = 3'h3;
  localparam logic [SEL_W-1:0] SEL_STATUS = 3'h4;
  localparam logic [SEL_W-1:0] SEL_SYS = 3'h5;
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_DRV_BIT = 1;
  localparam int unsigned CTRL_LATCH_BIT = 2;
  localparam int unsigned STAT_HI_BIT = 0;
  localparam int unsigned STAT_LO_BIT = 1;
  localparam int unsigned SYS_BUSY_BIT = 0;
  localparam int unsigned ASG_HI_LSB = 0;
  localparam int unsigned ASG_LO_LSB = 8;
  // Restore walk covers every stored word
  localparam logic [NVM_AW-1:0] NVM_LAST = 5'h1F;
  localparam logic [DW-1:0] DATA_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    AIM_ST_LOAD = 2'b00,
    AIM_ST_DRAIN = 2'b01,
    AIM_ST_RUN = 2'b10
  } aim_state_t;

  typedef struct packed {
    logic enable;
    logic drive;
    logic latch;
    logic [DW-1:0] hi_lim;
    logic [DW-1:0] lo_lim;
    logic [PT_W-1:0] hi_pt;
    logic [PT_W-1:0] lo_pt;
  } aim_cfg_t;

  localparam aim_cfg_t CFG_RESET = '0;

  // Host register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DW-1:0] wdata;
  } aim_req_t;

  // One finished conversion
  typedef struct packed {
    logic valid;
    logic [CH_W-1:0] ch;
    logic [DW-1:0] value;
  } aim_conv_t;
endpackage : aim_pkg
`default_nettype wire

// ===== bench/aim_nvm_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Non-volatile settings store seen by the monitor
// ----------------------------------------------------------------
module aim_nvm_model
  import aim_pkg::*;
(
  input wire logic i_core_clk,           // System clock
  input wire logic [NVM_AW-1:0] i_addr,  // Word address {channel, word}
  input wire logic [DW-1:0] i_wdata,     // Write data
  input wire logic i_we,                 // Write pulse
  input wire logic i_re,                 // Read pulse
  output logic [DW-1:0] o_rdata          // Data, cycle after a read
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [2**NVM_AW];
  // Preset image: channel 7 enabled and latching, so a restore is visible
  initial begin
    foreach (mem[i]) mem[i] = DATA_ZERO;
    mem[5'h1C] = 16'h0005;
    mem[5'h1D] = 16'h0100;
    mem[5'h1E] = 16'h0010;
    o_rdata = 16'h5a5a;
  end
  // Data is valid only after a read; otherwise it toggles so stale data is never trusted
  always @(posedge i_core_clk) begin
    if (i_we) mem[i_addr] <= i_wdata;
    if (i_re) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule : aim_nvm_model
`default_nettype wire

// ===== bench/aim_alarm_monitor_test.sv
`default_nettype none
module aim_alarm_monitor_test import aim_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic core_clk, sys_rst, nvm_we, nvm_re, busy;
  logic rd_seen = 1'b0;
  aim_req_t req;
  aim_conv_t conv;
  logic [DW-1:0] rd_data, nvm_wdata, nvm_rdata, hi, lo, v;
  logic [NVM_AW-1:0] nvm_addr;
  logic [NUM_CH-1:0] al_hi, al_lo;
  logic [NUM_PT-1:0] do_lvl, do_own;
  logic [PT_W-1:0] hp, lp;
  logic [1:0] e;
  logic [DW-1:0] exp_q[$];
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  aim_alarm_monitor dut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_req(req),
    .o_rd_data(rd_data), .i_conv(conv), .o_nvm_addr(nvm_addr), .o_nvm_wdata(nvm_wdata),
    .o_nvm_we(nvm_we), .o_nvm_re(nvm_re), .i_nvm_rdata(nvm_rdata), .o_busy(busy),
    .o_alarm_hi(al_hi), .o_alarm_lo(al_lo), .o_do_level(do_lvl), .o_do_owned(do_own));
  aim_nvm_model nvm (.i_core_clk(core_clk), .i_addr(nvm_addr), .i_wdata(nvm_wdata),
    .i_we(nvm_we), .i_re(nvm_re), .o_rdata(nvm_rdata));
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Comparison, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [NUM_PT-1:0] seen,
                       input logic [NUM_PT-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wr(input logic [CH_W-1:0] ch, input logic [SEL_W-1:0] sel,
                    input logic [DW-1:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: {ch, sel}, wdata: d};
    @(posedge core_clk);
    req <= '0;
  endtask : wr
  // Expected read data is queued here and compared by the watcher below
  task automatic rd(input logic [CH_W-1:0] ch, input logic [SEL_W-1:0] sel,
                    input logic [DW-1:0] exp);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: {ch, sel}, wdata: DATA_ZERO};
    exp_q.push_back(exp);
    @(posedge core_clk);
    req <= '0;
  endtask : rd
  // Returns once the alarm pins have settled, two cycles after the pulse
  task automatic cv(input logic [CH_W-1:0] ch, input logic [DW-1:0] val);
    @(posedge core_clk);
    conv <= '{valid: 1'b1, ch: ch, value: val};
    @(posedge core_clk);
    conv <= '0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : cv
  // Read data stands only in the cycle after the strobe; a hang counts as a mismatch
  always @(posedge core_clk) begin
    if (rd_seen) check("rd_data", rd_data, exp_q.pop_front());
    rd_seen <= req.rd;
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    conv = '0;
    sys_rst = 1'b1;
    void'($urandom(32'h60c2));
    repeat (8) @(posedge core_clk);
    check("busy_reset", busy, 1'b1);
    sys_rst <= 1'b0;
    rd(0, SEL_SYS, 16'h0001);
    wr(0, SEL_HI_LIM, 16'h1234);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    check("restore_done", busy, 1'b0);
    check("alarms_reset", {al_hi, al_lo}, 16'h0000);
    rd(7, SEL_CTRL, 16'h0005);
    rd(7, SEL_HI_LIM, 16'h0100);
    rd(7, SEL_LO_LIM, 16'h0010);
    rd(0, SEL_HI_LIM, 16'h0000);
    rd(0, 3'h6, 16'h0000);
    cv(7, 16'h0200);
    rd(7, SEL_STATUS, 16'h0001);
    // Channel 1: momentary, driving two random points in different slots
    hi = 16'h8000 | 16'($urandom % 4096);
    lo = 16'h1000 | 16'($urandom % 4096);
    hp = 7'($urandom);
    lp = hp ^ 7'h40;
    wr(1, SEL_HI_LIM, hi);
    wr(1, SEL_LO_LIM, lo);
    wr(1, SEL_ASSIGN, {1'b0, lp, 1'b0, hp});
    wr(1, SEL_CTRL, 16'h0003);
    rd(1, SEL_ASSIGN, {1'b0, lp, 1'b0, hp});
    check("nvm_hi", nvm.mem[5'h05], hi);
    check("nvm_lo", nvm.mem[5'h06], lo);
    check("nvm_ctrl", nvm.mem[5'h04], 16'h0003);
    cv(1, hi);
    rd(1, SEL_STATUS, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      case (i)
        0: v = hi + 16'h0001;
        1: v = lo - 16'h0001;
        2: v = 16'h4000;
        3: v = lo;
        default: v = 16'($urandom);
      endcase
      e = {v < lo, v > hi};
      cv(1, v);
      check("hi_pin", do_lvl[hp], e[0]);
      check("lo_pin", do_lvl[lp], e[1]);
      check("alarm_hi", al_hi[1], e[0]);
      check("alarm_lo", al_lo[1], e[1]);
      rd(1, SEL_STATUS, {14'h0, e});
    end
    // Channel 2: latching, no drive
    wr(2, SEL_HI_LIM, 16'h4000);
    wr(2, SEL_LO_LIM, 16'h2000);
    wr(2, SEL_CTRL, 16'h0005);
    cv(2, 16'h4001);
    rd(2, SEL_STATUS, 16'h0001);
    cv(2, 16'h3000);
    rd(2, SEL_STATUS, 16'h0001);
    rd(2, SEL_STATUS, 16'h0001);
    cv(2, 16'h1fff);
    rd(2, SEL_STATUS, 16'h0002);
    check("latched_lo", al_lo[2], 1'b1);
    wr(2, SEL_STATUS, 16'h0002);
    rd(2, SEL_STATUS, 16'h0000);
    // Channel 3: zero limits, so any evaluation would raise the high alarm
    cv(3, 16'hffff);
    rd(3, SEL_STATUS, 16'h0000);
    wr(3, SEL_CTRL, 16'h0001);
    cv(3, 16'hffff);
    rd(3, SEL_STATUS, 16'h0001);
    check("owned_mask", do_own, (128'h1 << hp) | (128'h1 << lp));
    repeat (3) @(posedge core_clk);
    check("queue_empty", exp_q.size(), 0);
    conclude();
  end
endmodule : aim_alarm_monitor_test
`default_nettype wire
